// >>> pkg/dcd_consts.svh
// constants of the class-zero command decoder: opcodes, codes, bit places
// assumes inclusion by the decoder, the engine model and the bench; no logic here
//
// Summary of operation
// - control bit 6 set: pass data uncorrected
// - control bit 6 clear: correct correctable data
// - read data reaches host even on errors
// - test ready: ready and no seek, else error
// - recalibrate to track zero, clear drive errors
// - syndrome: offset high, low, zero, mask
// - offset from bit zero; syndrome valid once
// - sense: byte, unit with address, mid, low
// - sense bit 7 only for error address
// - sense bits 5..4 carry error class
// - drive class error code values
// - media change blocks first media command
// - controller class error code values
// - command class codes; ram failure miscellaneous
// - format drive: all blocks, interleave, fill E5
// - check track: ids and interleave only
// - format bad track: bad flag, fill E5
// - read and write block count from byte 4
// - seek; overlapped drives complete before seek ends
// - assign alternate track, redirect later accesses
// - direct alternate track access gives code E
// - retry up to eight times unless disabled
// - byte 0 is class and opcode; class zero
// - status byte: unit, error bit, parity bit
`ifndef DCD_CONSTS_SVH
`define DCD_CONSTS_SVH
`define DCD_OP_TEST 5'h00
`define DCD_OP_RECAL 5'h01
`define DCD_OP_SYN 5'h02
`define DCD_OP_SENSE 5'h03
`define DCD_OP_FMT_DRV 5'h04
`define DCD_OP_CHK_TRK 5'h05
`define DCD_OP_FMT_TRK 5'h06
`define DCD_OP_FMT_BAD 5'h07
`define DCD_OP_READ 5'h08
`define DCD_OP_WRITE 5'h0A
`define DCD_OP_SEEK 5'h0B
`define DCD_OP_ALT 5'h0E
`define DCD_CLS_DRIVE 2'h0
`define DCD_CLS_CTRL 2'h1
`define DCD_CLS_CMD 2'h2
`define DCD_CLS_MISC 2'h3
`define DCD_DRV_NOT_READY 4'h4
`define DCD_DRV_MEDIA 4'h9
`define DCD_DRV_SEEKING 4'hD
`define DCD_CTL_UNCORR 4'h1
`define DCD_CTL_NO_REC 4'h4
`define DCD_CTL_SEEK_ERR 4'h5
`define DCD_CTL_CORR 4'h8
`define DCD_CTL_ALT_DIRECT 4'hE
`define DCD_CMD_INVALID 4'h0
`define DCD_FILL 8'hE5
`define DCD_CB_LAST 3'h5
`define DCD_RPL_LAST 2'h3
`define DCD_CB_NORETRY 7
`define DCD_CB_NOCORR 6
`endif

// >>> pkg/dcd_pkg.sv
// types shared by the class-zero command decoder and its bench
// assumes a byte-wide host bus and a separate media engine on one clock
package dcd_pkg;
    typedef enum logic [2:0] {
        S_CMD = 3'h0,
        S_EXEC = 3'h1,
        S_WAIT = 3'h3,
        S_STAT = 3'h2,
        S_DOUT = 3'h6,
        S_DIN = 3'h7
    } dcd_state_t;
    typedef struct packed {
        logic [7:0] data;
        logic cd;
        logic par;
    } dcd_hbyte_t;
    typedef struct packed {
        logic [7:0] data;
        logic cd;
    } dcd_obyte_t;
    typedef struct packed {
        logic [1:0] cls;
        logic [3:0] code;
    } dcd_err_t;
    typedef struct packed {
        logic [4:0] op;
        logic [2:0] unit;
        logic [20:0] addr;
        logic [8:0] count;
        logic [7:0] ilv;
        logic [20:0] alt_addr;
        logic no_correct;
        logic [7:0] fill;
    } dcd_eng_cmd_t;
    typedef struct packed {
        logic err;
        dcd_err_t code;
        logic addr_ok;
        logic [20:0] addr;
    } dcd_eng_rsp_t;
    typedef struct packed {
        logic [15:0] offset;
        logic [3:0] mask;
    } dcd_syn_t;
endpackage

// >>> rtl/dcd_decoder.sv
// class-zero command decoder: takes command blocks, runs them, answers
// assumes a media engine on sys_clk and drive status pins from outside
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_decoder #(
    parameter int UNITS = 8,
    parameter int RETRY_MAX = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire dcd_pkg::dcd_hbyte_t in_byte,
    input wire logic in_valid,
    output logic in_ready,
    output dcd_pkg::dcd_obyte_t out_byte,
    output logic out_valid,
    input wire logic out_ready,
    input wire logic [UNITS-1:0] drv_ready_pin,
    input wire logic [UNITS-1:0] drv_seek_pin,
    input wire logic [UNITS-1:0] media_chg_pin,
    output logic [UNITS-1:0] media_chg_ack,
    input wire logic overlap_seek,
    output logic eng_start,
    output dcd_pkg::dcd_eng_cmd_t eng_cmd,
    input wire logic eng_done,
    input wire dcd_pkg::dcd_eng_rsp_t eng_rsp,
    input wire logic eng_syn_load,
    input wire dcd_pkg::dcd_syn_t eng_syn,
    input wire logic [7:0] eng_rd_data,
    input wire logic eng_rd_valid,
    output logic eng_rd_ready,
    output logic [7:0] eng_wr_data,
    output logic eng_wr_valid,
    input wire logic eng_wr_ready
);
    // unit numbers are three bits wide; the retry counter is four
    if (UNITS < 1 || UNITS > 8) begin : g_units_chk
        $error("UNITS must lie in 1..8");
    end
    if (RETRY_MAX < 0 || RETRY_MAX > 15) begin : g_retry_chk
        $error("RETRY_MAX must lie in 0..15");
    end

    dcd_pkg::dcd_state_t state;
    logic [7:0] cb [6];
    logic [2:0] cb_idx;
    logic [1:0] din_idx, rpl_idx;
    logic [7:0] alt [3];
    logic [7:0] rpl [4];
    logic [3:0] retries;
    logic par_err, err_flag;
    logic [7:0] sense [UNITS];
    logic [20:0] sense_addr [UNITS];
    dcd_pkg::dcd_syn_t syn;
    logic syn_ok;
    logic [UNITS-1:0] rdy_s1, rdy_s2, skb_s1, skb_s2, chg_s1, chg_s2;
    dcd_pkg::dcd_obyte_t tl, next_hd, next_tl, push_byte;
    logic tl_vld, next_hd_vld, next_tl_vld, push, pop;
    logic log_err, log_aok, retry_now, in_fire;
    dcd_pkg::dcd_err_t log_code;
    logic [20:0] log_addr;

    wire [2:0] cmd_cls = cb[0][7:5];
    wire [4:0] op = cb[0][4:0];
    wire [2:0] unit = cb[1][7:5];
    wire [20:0] addr = {cb[1][4:0], cb[2], cb[3]};
    wire op_wr = (op == `DCD_OP_WRITE);
    wire [7:0] status_byte = {unit, 3'h0, err_flag, par_err};

    // odd parity over data and parity bit
    function automatic logic par_bad(input dcd_pkg::dcd_hbyte_t b);
        return ~^{b.data, b.par};
    endfunction

    // commands that touch the media, blocked after a media change
    function automatic logic is_media_op(input logic [4:0] o);
        return o == `DCD_OP_FMT_DRV || o == `DCD_OP_CHK_TRK ||
               o == `DCD_OP_FMT_TRK || o == `DCD_OP_FMT_BAD ||
               o == `DCD_OP_READ || o == `DCD_OP_WRITE || o == `DCD_OP_ALT;
    endfunction

    function automatic logic op_known(input logic [4:0] o);
        return o <= `DCD_OP_FMT_BAD || is_media_op(o) ||
               o == `DCD_OP_SEEK;
    endfunction

    // errors that a reread or recalibrate and reread may clear
    function automatic logic retryable(input dcd_pkg::dcd_err_t e);
        return e.cls == `DCD_CLS_CTRL &&
               (e.code == `DCD_CTL_UNCORR || e.code == `DCD_CTL_NO_REC ||
                e.code == `DCD_CTL_SEEK_ERR || e.code == `DCD_CTL_CORR);
    endfunction

    // engine order built from the command block
    function automatic dcd_pkg::dcd_eng_cmd_t mk_cmd(input logic [20:0] a);
        dcd_pkg::dcd_eng_cmd_t c;
        c.op = op;
        c.unit = unit;
        c.addr = addr;
        c.count = (cb[4] == 8'h00) ? 9'h100 : {1'b0, cb[4]};
        c.ilv = cb[4];
        c.alt_addr = a;
        c.no_correct = cb[5][`DCD_CB_NOCORR];
        c.fill = `DCD_FILL;
        return c;
    endfunction

    assign in_fire = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // drive pins come from another domain: two flops before use
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdy_s1 <= '0;
            rdy_s2 <= '0;
            skb_s1 <= '0;
            skb_s2 <= '0;
            chg_s1 <= '0;
            chg_s2 <= '0;
        end else if (clk_en) begin
            rdy_s1 <= drv_ready_pin;
            rdy_s2 <= rdy_s1;
            skb_s1 <= drv_seek_pin;
            skb_s2 <= skb_s1;
            chg_s1 <= media_chg_pin;
            chg_s2 <= chg_s1;
        end
    end

    // error found at decode or reported by the engine
    always_comb begin
        log_err = 1'b0;
        log_code = '0;
        log_aok = 1'b0;
        log_addr = '0;
        retry_now = state == dcd_pkg::S_WAIT && eng_done && eng_rsp.err &&
            retryable(eng_rsp.code) && !cb[5][`DCD_CB_NORETRY] &&
            (op == `DCD_OP_READ || op_wr) && 32'(retries) < RETRY_MAX;
        if (state == dcd_pkg::S_EXEC && !par_err) begin
            if (cmd_cls != 3'h0 || !op_known(op)) begin
                log_err = 1'b1;
                log_code = {`DCD_CLS_CMD, `DCD_CMD_INVALID};
            end else if (op == `DCD_OP_TEST && !rdy_s2[unit]) begin
                log_err = 1'b1;
                log_code = {`DCD_CLS_DRIVE, `DCD_DRV_NOT_READY};
            end else if (op == `DCD_OP_TEST && skb_s2[unit]) begin
                log_err = 1'b1;
                log_code = {`DCD_CLS_DRIVE, `DCD_DRV_SEEKING};
            end else if (is_media_op(op) && chg_s2[unit]) begin
                log_err = 1'b1;
                log_code = {`DCD_CLS_DRIVE, `DCD_DRV_MEDIA};
            end
        end else if (state == dcd_pkg::S_WAIT && eng_done && eng_rsp.err &&
                     !retry_now) begin
            // engine codes pass through unchanged
            log_err = 1'b1;
            log_code = eng_rsp.code;
            log_aok = eng_rsp.addr_ok;
            log_addr = eng_rsp.addr;
        end
    end

    // per-unit sense, kept until the next command other than sense or syndrome to that unit
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < UNITS; i++) begin
                sense[i] <= 8'h00;
                sense_addr[i] <= '0;
            end
        end else if (clk_en) begin
            if (log_err) begin
                sense[unit] <= {log_aok, 1'b0, log_code};
                sense_addr[unit] <= log_addr;
            end else if (state == dcd_pkg::S_EXEC && op != `DCD_OP_SENSE &&
                         op != `DCD_OP_SYN) begin
                sense[unit] <= 8'h00;
                sense_addr[unit] <= '0;
            end
        end
    end

    // syndrome holds only until some other command arrives; load wins
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            syn <= '0;
            syn_ok <= 1'b0;
        end else if (clk_en) begin
            if (eng_syn_load) begin
                syn <= eng_syn;
                syn_ok <= 1'b1;
            end else if (state == dcd_pkg::S_EXEC && op != `DCD_OP_SYN) begin
                syn_ok <= 1'b0;
            end
        end
    end

    // source of the next byte for the host
    always_comb begin
        push = 1'b0;
        push_byte = '0;
        if (state == dcd_pkg::S_WAIT && eng_rd_valid && eng_rd_ready) begin
            push = 1'b1;
            push_byte = {eng_rd_data, 1'b0};
        end else if (state == dcd_pkg::S_DOUT && !tl_vld) begin
            push = 1'b1;
            push_byte = {rpl[rpl_idx], 1'b0};
        end else if (state == dcd_pkg::S_STAT && !tl_vld) begin
            push = 1'b1;
            push_byte = {status_byte, 1'b1};
        end
    end

    // two-entry buffer: head drives the port, tail absorbs one stall
    always_comb begin
        next_hd = out_byte;
        next_hd_vld = out_valid;
        next_tl = tl;
        next_tl_vld = tl_vld;
        if (pop) begin
            next_hd = tl;
            next_hd_vld = tl_vld;
            next_tl_vld = 1'b0;
        end
        if (push) begin
            if (!next_hd_vld) begin
                next_hd = push_byte;
                next_hd_vld = 1'b1;
            end else begin
                next_tl = push_byte;
                next_tl_vld = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            out_byte <= '0;
            out_valid <= 1'b0;
            tl <= '0;
            tl_vld <= 1'b0;
            eng_rd_ready <= 1'b0;
        end else if (clk_en) begin
            out_byte <= next_hd;
            out_valid <= next_hd_vld;
            tl <= next_tl;
            tl_vld <= next_tl_vld;
            eng_rd_ready <= !next_tl_vld; // host stall reaches the engine
        end
    end

    // command sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= dcd_pkg::S_CMD;
            for (int i = 0; i < 6; i++) cb[i] <= 8'h00;
            for (int i = 0; i < 3; i++) alt[i] <= 8'h00;
            for (int i = 0; i < 4; i++) rpl[i] <= 8'h00;
            cb_idx <= 3'h0;
            din_idx <= 2'h0;
            rpl_idx <= 2'h0;
            retries <= 4'h0;
            par_err <= 1'b0;
            err_flag <= 1'b0;
            in_ready <= 1'b0;
            eng_start <= 1'b0;
            eng_cmd <= '0;
            eng_wr_data <= 8'h00;
            eng_wr_valid <= 1'b0;
            media_chg_ack <= '0;
        end else if (clk_en) begin
            eng_start <= 1'b0;
            media_chg_ack <= '0;
            if (eng_wr_valid && eng_wr_ready) eng_wr_valid <= 1'b0;
            case (state)
                dcd_pkg::S_CMD: begin
                    in_ready <= 1'b1;
                    if (in_fire) begin
                        cb[cb_idx] <= in_byte.data;
                        par_err <= par_err | par_bad(in_byte);
                        if (cb_idx == `DCD_CB_LAST) begin
                            cb_idx <= 3'h0;
                            in_ready <= 1'b0;
                            state <= dcd_pkg::S_EXEC;
                        end else begin
                            cb_idx <= cb_idx + 3'h1;
                        end
                    end
                end
                dcd_pkg::S_EXEC: begin
                    retries <= 4'h0;
                    if (par_err || log_err) begin
                        err_flag <= log_err;
                        if (is_media_op(op) && chg_s2[unit])
                            media_chg_ack[unit] <= 1'b1;
                        state <= dcd_pkg::S_STAT;
                    end else begin
                        case (op)
                            `DCD_OP_TEST: state <= dcd_pkg::S_STAT;
                            `DCD_OP_SYN: begin
                                rpl[0] <= syn_ok ? syn.offset[15:8] : 8'h00;
                                rpl[1] <= syn_ok ? syn.offset[7:0] : 8'h00;
                                rpl[2] <= 8'h00;
                                rpl[3] <= {4'h0, syn_ok ? syn.mask : 4'h0};
                                state <= dcd_pkg::S_DOUT;
                            end
                            `DCD_OP_SENSE: begin
                                rpl[0] <= sense[unit];
                                rpl[1] <= {unit, sense_addr[unit][20:16]};
                                rpl[2] <= sense_addr[unit][15:8];
                                rpl[3] <= sense_addr[unit][7:0];
                                state <= dcd_pkg::S_DOUT;
                            end
                            `DCD_OP_ALT: begin
                                din_idx <= 2'h0;
                                in_ready <= 1'b1;
                                state <= dcd_pkg::S_DIN;
                            end
                            default: begin
                                // recal, format, check track, read, write and seek go to the engine
                                eng_start <= 1'b1;
                                eng_cmd <= mk_cmd(21'h0);
                                in_ready <= op_wr;
                                if (op == `DCD_OP_SEEK && overlap_seek)
                                    state <= dcd_pkg::S_STAT;
                                else
                                    state <= dcd_pkg::S_WAIT;
                            end
                        endcase
                    end
                end
                dcd_pkg::S_DIN: begin
                    if (in_fire) begin
                        par_err <= par_err | par_bad(in_byte);
                        if (din_idx != `DCD_RPL_LAST) begin
                            alt[din_idx] <= in_byte.data;
                            din_idx <= din_idx + 2'h1;
                        end else begin
                            // spare byte ends the address; start
                            in_ready <= 1'b0;
                            eng_start <= 1'b1;
                            eng_cmd <= mk_cmd({alt[0][4:0], alt[1], alt[2]});
                            state <= dcd_pkg::S_WAIT;
                        end
                    end
                end
                dcd_pkg::S_WAIT: begin
                    // one byte held toward the engine; ready lags a cycle
                    if (in_fire) begin
                        eng_wr_data <= in_byte.data;
                        eng_wr_valid <= 1'b1;
                        par_err <= par_err | par_bad(in_byte);
                    end
                    in_ready <= op_wr && !in_fire &&
                        !(eng_wr_valid && !eng_wr_ready);
                    if (eng_done) begin
                        if (retry_now) begin
                            retries <= retries + 4'h1;
                            eng_start <= 1'b1;
                        end else begin
                            err_flag <= eng_rsp.err;
                            in_ready <= 1'b0;
                            state <= dcd_pkg::S_STAT;
                        end
                    end
                end
                dcd_pkg::S_DOUT: begin
                    if (!tl_vld) begin
                        if (rpl_idx == `DCD_RPL_LAST) begin
                            rpl_idx <= 2'h0;
                            state <= dcd_pkg::S_STAT;
                        end else begin
                            rpl_idx <= rpl_idx + 2'h1;
                        end
                    end
                end
                dcd_pkg::S_STAT: begin
                    if (!tl_vld) begin
                        par_err <= 1'b0;
                        err_flag <= 1'b0;
                        in_ready <= 1'b1;
                        state <= dcd_pkg::S_CMD;
                    end
                end
                default: state <= dcd_pkg::S_CMD;
            endcase
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_exec_ok;
        state == dcd_pkg::S_EXEC && clk_en && !par_err && !log_err;
    endsequence
    sequence s_seek_go;
        s_exec_ok ##0 op == `DCD_OP_SEEK && overlap_seek;
    endsequence

    a_class_reject: assert property (
        state == dcd_pkg::S_EXEC && clk_en && !par_err && cmd_cls != 3'h0
        |=> sense[unit][5:0] == {`DCD_CLS_CMD, `DCD_CMD_INVALID} && err_flag)
        else $error("bad class not rejected");
    a_no_correct: assert property (
        eng_start |-> eng_cmd.no_correct == cb[5][`DCD_CB_NOCORR])
        else $error("correction control lost");
    a_test_ready: assert property (
        state == dcd_pkg::S_EXEC && clk_en && !par_err && cmd_cls == 3'h0 &&
        op == `DCD_OP_TEST && !rdy_s2[unit]
        |=> state == dcd_pkg::S_STAT && err_flag)
        else $error("not ready drive passed");
    a_media_block: assert property (
        state == dcd_pkg::S_EXEC && clk_en && !par_err && cmd_cls == 3'h0 &&
        is_media_op(op) && chg_s2[unit]
        |=> !eng_start && media_chg_ack[unit] &&
            sense[unit][3:0] == `DCD_DRV_MEDIA)
        else $error("media change not blocked");
    a_syn_zero: assert property (
        state == dcd_pkg::S_DOUT && op == `DCD_OP_SYN && push &&
        rpl_idx == 2'h2 |-> push_byte.data == 8'h00)
        else $error("syndrome third byte not zero");
    a_retry_bound: assert property (
        eng_start && cb[5][`DCD_CB_NORETRY] |-> retries == 4'h0)
        else $error("retry despite disable");
    a_block_count: assert property (
        eng_start && eng_cmd.op == `DCD_OP_READ |->
        eng_cmd.count == ((cb[4] == 8'h00) ? 9'h100 : {1'b0, cb[4]}))
        else $error("block count wrong");
    a_overlap_seek: assert property (
        s_seek_go |=> eng_start && state == dcd_pkg::S_STAT)
        else $error("overlapped seek waited");
    a_status_unit: assert property (
        push && state == dcd_pkg::S_STAT |->
        push_byte.data[7:5] == unit && push_byte.data[1] == err_flag &&
        push_byte.cd)
        else $error("status byte malformed");
    a_syn_clear: assert property (
        state == dcd_pkg::S_EXEC && clk_en && op != `DCD_OP_SYN &&
        !eng_syn_load |=> !syn_ok)
        else $error("syndrome outlived command");
    a_read_pass: assert property (
        state == dcd_pkg::S_WAIT && clk_en && eng_rd_valid && eng_rd_ready
        |=> out_valid)
        else $error("read byte dropped");
endmodule

// >>> sim/dcd_eng_model.sv
// behavioural media engine facing the decoder's engine port
// assumes the bench scripts failures through fails and code
`timescale 1ns/1ps
`include "dcd_consts.svh"
module dcd_eng_model (
    input wire logic sys_clk,
    input wire logic eng_start,
    input wire dcd_pkg::dcd_eng_cmd_t eng_cmd,
    output logic eng_done,
    output dcd_pkg::dcd_eng_rsp_t eng_rsp,
    output logic eng_syn_load,
    output dcd_pkg::dcd_syn_t eng_syn,
    output logic [7:0] eng_rd_data,
    output logic eng_rd_valid,
    input wire logic eng_rd_ready,
    output logic eng_wr_ready
);
    int fails = 0;
    int starts = 0;
    dcd_pkg::dcd_err_t code = '0;
    logic bad;
    // one op at a time; failing tries move no data except reads with code 8
    initial begin
        {eng_done, eng_syn_load, eng_rd_valid, eng_wr_ready} = 4'h1;
        eng_rsp = '0;
        eng_syn = '0;
        eng_rd_data = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (eng_start === 1'h1) begin
                starts++;
                bad = fails > 0;
                if (bad) fails--;
                repeat (3) @(posedge sys_clk);
                if (eng_cmd.op == `DCD_OP_READ &&
                    (!bad || code.code == `DCD_CTL_CORR)) begin
                    eng_rd_valid <= 1'h1;
                    for (int i = 0; i < eng_cmd.count; i++) begin
                        eng_rd_data <= 8'hA0 + 8'(i);
                        do @(posedge sys_clk); while (eng_rd_ready !== 1'h1);
                    end
                    eng_rd_valid <= 1'h0;
                    eng_rd_data <= ~eng_rd_data;
                end
                eng_done <= 1'h1;
                eng_rsp <= bad ? {1'h1, code, 1'h1, eng_cmd.addr} : '0;
                eng_syn_load <= bad;
                eng_syn <= {16'h0123, 4'h5};
                @(posedge sys_clk);
                eng_done <= 1'h0;
                eng_syn_load <= 1'h0;
                eng_rsp <= ~eng_rsp; // stale answer must not pass for valid
            end
        end
    end
endmodule

// >>> sim/tb_dcd_decoder.sv
// self-checking bench for the class-zero command decoder
// assumes the engine model above; host always ready to take bytes
`timescale 1ns/1ps
`include "dcd_consts.svh"
module tb_dcd_decoder;
    typedef logic [7:0] dcd_cb_t [6];
    typedef struct {logic [7:0] b0, rdy, sk, sen; logic [2:0] u; logic e;} dcd_row_t;
    dcd_row_t rows [6] = '{'{8'h00, 8'hFF, 8'h00, 8'h00, 3'h1, 1'h0},
        '{8'h00, 8'hFF, 8'h04, 8'h0D, 3'h2, 1'h1},
        '{8'h00, 8'hF7, 8'h00, 8'h04, 3'h3, 1'h1},
        '{8'h09, 8'hFF, 8'h00, 8'h20, 3'h0, 1'h1},
        '{8'h20, 8'hFF, 8'h00, 8'h20, 3'h5, 1'h1},
        '{8'h0B, 8'hFF, 8'h00, 8'h00, 3'h6, 1'h0}};
    logic sys_clk = 0, rst_b = 0, in_valid = 0, in_ready, out_valid;
    logic eng_start, eng_done, eng_syn_load, eng_rd_valid, eng_rd_ready;
    logic eng_wr_ready, ack_seen = 0;
    logic [7:0] drv_ready_pin = 8'hFF, drv_seek_pin = 8'h00;
    logic [7:0] media_chg_pin = 8'h00, media_chg_ack, eng_rd_data;
    dcd_pkg::dcd_hbyte_t in_byte = '0;
    dcd_pkg::dcd_obyte_t out_byte;
    dcd_pkg::dcd_eng_cmd_t eng_cmd;
    dcd_pkg::dcd_eng_rsp_t eng_rsp;
    dcd_pkg::dcd_syn_t eng_syn;
    int err_count = 0, num_checks = 0, s0;
    dcd_decoder i_dcd_decoder (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(1'h1), .in_byte(in_byte), .in_valid(in_valid),
        .in_ready(in_ready), .out_byte(out_byte), .out_valid(out_valid),
        .out_ready(1'h1), .drv_ready_pin(drv_ready_pin),
        .drv_seek_pin(drv_seek_pin), .media_chg_pin(media_chg_pin),
        .media_chg_ack(media_chg_ack), .overlap_seek(1'h1),
        .eng_start(eng_start), .eng_cmd(eng_cmd), .eng_done(eng_done),
        .eng_rsp(eng_rsp), .eng_syn_load(eng_syn_load), .eng_syn(eng_syn),
        .eng_rd_data(eng_rd_data), .eng_rd_valid(eng_rd_valid),
        .eng_rd_ready(eng_rd_ready), .eng_wr_data(), .eng_wr_valid(),
        .eng_wr_ready(eng_wr_ready));
    dcd_eng_model i_dcd_eng_model (.sys_clk(sys_clk), .eng_start(eng_start),
        .eng_cmd(eng_cmd), .eng_done(eng_done), .eng_rsp(eng_rsp),
        .eng_syn_load(eng_syn_load), .eng_syn(eng_syn),
        .eng_rd_data(eng_rd_data), .eng_rd_valid(eng_rd_valid),
        .eng_rd_ready(eng_rd_ready), .eng_wr_ready(eng_wr_ready));
    // clock at 100 MHz
    initial forever #5 sys_clk = ~sys_clk;
    // the ack is a one-cycle pulse, so it is latched for a later look
    always @(posedge sys_clk) if (media_chg_ack[4] === 1'h1) ack_seen <= 1'h1;
    function automatic dcd_cb_t mk(logic [7:0] op, logic [2:0] u,
        logic [20:0] a, logic [7:0] n, c);
        return '{op, {u, a[20:16]}, a[15:8], a[7:0], n, c};
    endfunction
    function automatic logic [8:0] st(logic [2:0] u, logic e);
        return {u, 3'h0, e, 1'h0, 1'h1};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(string nm, logic [20:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(inout int n);
        @(negedge sys_clk);
        if (++n > 2000) begin
            err_count++;
            tally_and_finish;
        end
    endtask
    // tasks start and end at a falling edge
    task automatic run(dcd_cb_t cb, logic [8:0] ex [$], logic [7:0] care);
        int n = 0;
        logic [7:0] d;
        for (int i = 0; i < (cb[0] == 8'h0E ? 10 : 6); i++) begin
            d = i < 6 ? cb[i] : cb[i-4] & (i == 6 ? 8'h1F : {8{i < 9}});
            in_byte = {d, i < 6, ~^d};
            in_valid = 1'h1;
            while (in_ready !== 1'h1) step(n);
            @(negedge sys_clk);
        end
        in_valid = 1'h0;
        in_byte = ~in_byte;
        foreach (ex[i]) begin
            while (out_valid !== 1'h1) step(n);
            if (care[i]) check("out_byte", out_byte, ex[i]);
            @(negedge sys_clk);
        end
    endtask
    initial begin
        repeat (4) @(negedge sys_clk);
        rst_b = 1'h1;
        check("idle", {in_ready, out_valid}, 9'h000);
        foreach (rows[i]) begin
            drv_ready_pin = rows[i].rdy;
            drv_seek_pin = rows[i].sk;
            repeat (4) @(negedge sys_clk); // pins pass a 2-flop sync
            run(mk(rows[i].b0, rows[i].u, 0, 0, 0), '{st(rows[i].u, rows[i].e)}, 8'hFF);
            run(mk(8'h03, rows[i].u, 0, 0, 0), '{{rows[i].sen, 1'h0}, 0, 0, 0, st(rows[i].u, 0)}, 8'h11);
        end
        i_dcd_eng_model.fails = 1;
        i_dcd_eng_model.code = {2'h1, 4'h8};
        run(mk(8'h08, 2, 21'h1ABCDE, 2, 8'hC0), '{9'h140, 9'h142, st(2, 1)}, 8'hFF);
        check("no_correct", eng_cmd.no_correct, 1);
        check("count", eng_cmd.count, 9'h002);
        run(mk(8'h02, 2, 0, 0, 0), '{9'h002, 9'h046, 0, 9'h00A, st(2, 0)}, 8'hFF);
        run(mk(8'h03, 2, 0, 0, 0), '{9'h130, 9'h0B4, 9'h178, 9'h1BC, st(2, 0)}, 8'hFF);
        run(mk(8'h02, 2, 0, 0, 0), '{0, 0, 0, 0, st(2, 0)}, 8'hFF);
        i_dcd_eng_model.fails = 1;
        i_dcd_eng_model.code = {2'h1, 4'h4};
        s0 = i_dcd_eng_model.starts;
        run(mk(8'h08, 0, 21'h000010, 1, 0), '{9'h140, st(0, 0)}, 8'hFF);
        check("tries", 9'(i_dcd_eng_model.starts - s0), 9'h002);
        check("no_correct", eng_cmd.no_correct, 0);
        run(mk(8'h03, 0, 0, 0, 0), '{0, 0, 0, 0, st(0, 0)}, 8'h11);
        media_chg_pin = 8'h10;
        repeat (4) @(negedge sys_clk);
        s0 = i_dcd_eng_model.starts;
        run(mk(8'h08, 4, 0, 1, 0), '{st(4, 1)}, 8'hFF);
        check("starts", 9'(i_dcd_eng_model.starts - s0), 9'h000);
        check("ack", ack_seen, 1);
        media_chg_pin = 8'h00;
        run(mk(8'h03, 4, 0, 0, 0), '{9'h012, 0, 0, 0, st(4, 0)}, 8'h11);
        run(mk(8'h0E, 1, 21'h012345, 8'h67, 0), '{st(1, 0)}, 8'hFF);
        check("alt", eng_cmd.alt_addr, 21'h034567);
        tally_and_finish;
    end
endmodule
